// ---- rtl/adcsr_consts.svh ----
`ifndef ADCSR_CONSTS_SVH
`define ADCSR_CONSTS_SVH

// serial frame geometry
`define ADCSR_FRAME_EDGES     5'd16
`define ADCSR_LAST_LAUNCH     5'd15
`define ADCSR_EDGE_DOWN_MIN   5'd2
`define ADCSR_EDGE_AWAKE      5'd10
`define ADCSR_EDGE_TRACK      5'd13
`define ADCSR_RESULT_BITS     12
`define ADCSR_LEAD_ZEROS      4
`define ADCSR_LEAD_VAL        4'h0

// synchroniser bit positions
`define ADCSR_SY_CS_B         0
`define ADCSR_SY_GE2          1
`define ADCSR_SY_GE10         2
`define ADCSR_SY_DONE16       3
`define ADCSR_SY_EDGE         4
`define ADCSR_SY_TRACK13      5
`define ADCSR_SY_STRAP        6
`define ADCSR_SY_WIDTH        7

// timing
`define ADCSR_CLK_PERIOD_NS   25
`define ADCSR_POWER_UP_NS     1000
`define ADCSR_POWER_UP_CYC    \
    ((`ADCSR_POWER_UP_NS + `ADCSR_CLK_PERIOD_NS - 1) / `ADCSR_CLK_PERIOD_NS)
`define ADCSR_PUP_W           6
// core cycles after reset release until the strap has crossed both flops
`define ADCSR_SYNC_FILL       6'd2

`endif

// ---- rtl/adcsr_pkg.sv ----
`include "adcsr_consts.svh"

package adcsr_pkg;

    typedef enum logic [3:0] {
        ST_NORMAL   = 4'b0001,
        ST_DOWN     = 4'b0010,
        ST_WAKING   = 4'b0100,
        ST_POWERING = 4'b1000
    } adcsr_state_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic       dataBit;
        logic       done;
    } adcsr_fall_t;

    typedef struct packed {
        logic risen;
        logic track13;
    } adcsr_rise_t;

    typedef struct packed {
        logic [`ADCSR_SY_WIDTH-1:0] stage1;
        logic [`ADCSR_SY_WIDTH-1:0] stage2;
    } adcsr_sync_t;

    typedef struct packed {
        adcsr_state_t                  state;
        logic [`ADCSR_PUP_W-1:0]       pupCnt;
        logic                          prevLow;
        logic                          seen2;
        logic                          seen10;
        logic                          seen16;
        logic [`ADCSR_RESULT_BITS-1:0] code;
        logic                          hold;
        logic                          trusted;
        logic                          strapPending;
    } adcsr_core_t;

endpackage : adcsr_pkg

// ---- rtl/adcsr_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "adcsr_consts.svh"

module adcsr_sync (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic [`ADCSR_SY_WIDTH-1:0] asyncIn,
    output logic      [`ADCSR_SY_WIDTH-1:0] syncOut
);

    adcsr_pkg::adcsr_sync_t sy_r;
    adcsr_pkg::adcsr_sync_t sy_nxt;

    always_comb begin
        sy_nxt        = sy_r;
        sy_nxt.stage1 = asyncIn;
        sy_nxt.stage2 = sy_r.stage1;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            // chip select idles high
            sy_r <= '{stage1: 7'h01, stage2: 7'h01};
        end else begin
            sy_r <= sy_nxt;
        end
    end

    // only the second stage is visible
    genvar i;
    generate
        for (i = 0; i < `ADCSR_SY_WIDTH; i = i + 1) begin : g_out
            assign syncOut[i] = sy_r.stage2[i];
        end
    endgenerate

endmodule : adcsr_sync

`default_nettype wire

// ---- rtl/adcsr_link.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "adcsr_consts.svh"

module adcsr_link (
    input  wire logic        sclk,
    input  wire logic        chipSelB,
    input  wire logic [15:0] frameWord,
    output logic             serialResultOut,
    output logic             serialResultOutOeB,
    output logic             countGe2,
    output logic             countGe10,
    output logic             countDone16,
    output logic             edgeSeen,
    output logic             trackAfter13
);

    adcsr_pkg::adcsr_fall_t fall_r;
    adcsr_pkg::adcsr_fall_t fall_nxt;
    adcsr_pkg::adcsr_rise_t rise_r;
    adcsr_pkg::adcsr_rise_t rise_nxt;

    ////////////////////////////////////////////////////////////////////////
    // falling edges: count, launch next bit
    always_comb begin
        fall_nxt = fall_r;
        if (fall_r.cnt != `ADCSR_FRAME_EDGES) begin
            fall_nxt.cnt = fall_r.cnt + 5'd1;
        end
        if (fall_nxt.cnt <= `ADCSR_LAST_LAUNCH) begin
            fall_nxt.dataBit = frameWord[4'(`ADCSR_LAST_LAUNCH - fall_nxt.cnt)];
        end else begin
            fall_nxt.dataBit = 1'b0;
        end
        fall_nxt.done = (fall_nxt.cnt == `ADCSR_FRAME_EDGES);
    end

    // frame end clears the link side at once
    always_ff @(negedge sclk or posedge chipSelB) begin
        if (chipSelB) begin
            fall_r <= '0;
        end else begin
            fall_r <= fall_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rising edges: first edge and track point
    always_comb begin
        rise_nxt         = rise_r;
        rise_nxt.risen   = 1'b1;
        rise_nxt.track13 = rise_r.track13
                           | (fall_r.cnt >= `ADCSR_EDGE_TRACK);
    end

    always_ff @(posedge sclk or posedge chipSelB) begin
        if (chipSelB) begin
            rise_r <= '0;
        end else begin
            rise_r <= rise_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign serialResultOut    = fall_r.dataBit;
    assign serialResultOutOeB = chipSelB | fall_r.done;
    assign countGe2           = fall_r.cnt >= `ADCSR_EDGE_DOWN_MIN;
    assign countGe10          = fall_r.cnt >= `ADCSR_EDGE_AWAKE;
    assign countDone16        = fall_r.done;
    assign edgeSeen           = rise_r.risen | (fall_r.cnt != 5'd0);
    assign trackAfter13       = rise_r.track13;

endmodule : adcsr_link

`default_nettype wire

// ---- rtl/adcsr_readout.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "adcsr_consts.svh"

module adcsr_readout (
    input  wire logic                          core_clk,
    input  wire logic                          rst_b,
    input  wire logic                          sclk,
    input  wire logic                          chipSelB,
    input  wire logic                          powerOnDownStrap,
    input  wire logic [`ADCSR_RESULT_BITS-1:0] conversionCode,
    output logic                               serialResultOut,
    output logic                               serialResultOutOeB,
    output logic                               analogPowerOn,
    output logic                               sampleHold,
    output logic                               resultTrusted
);

    localparam logic [`ADCSR_PUP_W-1:0] PUP_CYC =
        `ADCSR_PUP_W'(`ADCSR_POWER_UP_CYC);

    adcsr_pkg::adcsr_core_t       st_r;
    adcsr_pkg::adcsr_core_t       st_nxt;
    logic [15:0]                  frameWord;
    logic [`ADCSR_SY_WIDTH-1:0]   rawFlags;
    logic [`ADCSR_SY_WIDTH-1:0]   syncFlags;
    logic                         linkGe2;
    logic                         linkGe10;
    logic                         linkDone16;
    logic                         linkEdge;
    logic                         linkTrack13;
    logic                         csLow;
    logic                         frameStart;
    logic                         frameEnd;
    logic                         pupDone;

    ////////////////////////////////////////////////////////////////////////
    // frame classification
    function automatic logic inDownWindow(input logic ge2, input logic ge10);
        inDownWindow = ge2 & ~ge10;
    endfunction : inDownWindow

    function automatic logic keepsPower(input logic ge10);
        keepsPower = ge10;
    endfunction : keepsPower

    ////////////////////////////////////////////////////////////////////////
    // link side
    assign frameWord = {`ADCSR_LEAD_VAL, st_r.code};

    adcsr_link u_link (
        .sclk               (sclk),
        .chipSelB           (chipSelB),
        .frameWord          (frameWord),
        .serialResultOut    (serialResultOut),
        .serialResultOutOeB (serialResultOutOeB),
        .countGe2           (linkGe2),
        .countGe10          (linkGe10),
        .countDone16        (linkDone16),
        .edgeSeen           (linkEdge),
        .trackAfter13       (linkTrack13)
    );

    ////////////////////////////////////////////////////////////////////////
    // crossing into core domain
    always_comb begin
        rawFlags                      = '0;
        rawFlags[`ADCSR_SY_CS_B]      = chipSelB;
        rawFlags[`ADCSR_SY_GE2]       = linkGe2;
        rawFlags[`ADCSR_SY_GE10]      = linkGe10;
        rawFlags[`ADCSR_SY_DONE16]    = linkDone16;
        rawFlags[`ADCSR_SY_EDGE]      = linkEdge;
        rawFlags[`ADCSR_SY_TRACK13]   = linkTrack13;
        rawFlags[`ADCSR_SY_STRAP]     = powerOnDownStrap;
    end

    adcsr_sync u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .asyncIn  (rawFlags),
        .syncOut  (syncFlags)
    );

    assign csLow      = ~syncFlags[`ADCSR_SY_CS_B];
    assign frameStart = csLow & ~st_r.prevLow;
    assign frameEnd   = ~csLow & st_r.prevLow;
    assign pupDone    = (st_r.pupCnt >= PUP_CYC);

    ////////////////////////////////////////////////////////////////////////
    // power sequencing
    always_comb begin
        st_nxt         = st_r;
        st_nxt.prevLow = csLow;

        // result frozen while a frame runs
        if (!csLow) begin
            st_nxt.code = conversionCode;
        end

        // frame progress, sticky until next frame start
        if (frameStart) begin
            st_nxt.seen2  = 1'b0;
            st_nxt.seen10 = 1'b0;
            st_nxt.seen16 = 1'b0;
        end else if (csLow) begin
            st_nxt.seen2  = st_r.seen2  | syncFlags[`ADCSR_SY_GE2];
            st_nxt.seen10 = st_r.seen10 | syncFlags[`ADCSR_SY_GE10];
            st_nxt.seen16 = st_r.seen16 | syncFlags[`ADCSR_SY_DONE16];
        end

        if (st_r.pupCnt != {`ADCSR_PUP_W{1'b1}}) begin
            st_nxt.pupCnt = st_r.pupCnt + `ADCSR_PUP_W'(1);
        end

        case (st_r.state)
            adcsr_pkg::ST_NORMAL: begin
                if (frameEnd) begin
                    if (inDownWindow(st_r.seen2, st_r.seen10)) begin
                        st_nxt.state   = adcsr_pkg::ST_DOWN;
                        st_nxt.trusted = 1'b0;
                    end else if (keepsPower(st_r.seen10)) begin
                        st_nxt.trusted = 1'b1;
                    end
                end
            end
            adcsr_pkg::ST_DOWN: begin
                if (frameStart) begin
                    st_nxt.state  = adcsr_pkg::ST_WAKING;
                    st_nxt.pupCnt = '0;
                end
            end
            adcsr_pkg::ST_WAKING: begin
                if (frameEnd) begin
                    if (!keepsPower(st_r.seen10)) begin
                        st_nxt.state = adcsr_pkg::ST_DOWN;
                    end else if (pupDone) begin
                        st_nxt.state   = adcsr_pkg::ST_NORMAL;
                        st_nxt.trusted = 1'b1;
                    end else begin
                        st_nxt.state = adcsr_pkg::ST_POWERING;
                    end
                end
            end
            adcsr_pkg::ST_POWERING: begin
                if (pupDone) begin
                    st_nxt.state   = adcsr_pkg::ST_NORMAL;
                    st_nxt.trusted = 1'b1;
                end
            end
            default: begin
                st_nxt.state = adcsr_pkg::ST_DOWN;
            end
        endcase

        // supply-on mode taken from strap once the synchroniser has filled
        if (st_r.strapPending && (st_r.pupCnt >= `ADCSR_SYNC_FILL)) begin
            st_nxt.strapPending = 1'b0;
            st_nxt.trusted      = 1'b0;
            st_nxt.pupCnt       = '0;
            if (syncFlags[`ADCSR_SY_STRAP]) begin
                st_nxt.state = adcsr_pkg::ST_DOWN;
            end else begin
                st_nxt.state = adcsr_pkg::ST_POWERING;
            end
        end

        // sample stage control
        case (st_nxt.state)
            adcsr_pkg::ST_DOWN: begin
                // supply-on power-down keeps tracking until first frame
                if (st_r.strapPending || (st_r.state == adcsr_pkg::ST_DOWN)) begin
                    st_nxt.hold = st_r.hold;
                end else begin
                    st_nxt.hold = 1'b1;
                end
            end
            adcsr_pkg::ST_WAKING: begin
                st_nxt.hold = ~syncFlags[`ADCSR_SY_EDGE];
            end
            default: begin
                st_nxt.hold = csLow & ~syncFlags[`ADCSR_SY_TRACK13];
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_r <= '{state:        adcsr_pkg::ST_NORMAL,
                      pupCnt:       '0,
                      prevLow:      1'b0,
                      seen2:        1'b0,
                      seen10:       1'b0,
                      seen16:       1'b0,
                      code:         '0,
                      hold:         1'b0,
                      trusted:      1'b0,
                      strapPending: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign analogPowerOn = (st_r.state != adcsr_pkg::ST_DOWN);
    assign sampleHold    = st_r.hold;
    assign resultTrusted = st_r.trusted;

endmodule : adcsr_readout

`default_nettype wire

// ---- dv/adcsr_readout_properties.sv ----
`timescale 1ns/100ps
`default_nettype none

module adcsr_readout_properties (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        sclk,
    input wire logic        chipSelB,
    input wire logic [11:0] conversionCode,
    input wire logic        serialResultOut,
    input wire logic        serialResultOutOeB,
    input wire logic        analogPowerOn,
    input wire logic        sampleHold,
    input wire logic        resultTrusted
);
    logic [4:0]  fallCnt    = 5'h00;
    logic [4:0]  lastCnt    = 5'h00;
    logic [11:0] codeHeld   = 12'h000;
    logic        downAtFall = 1'b0;

    // falls seen in the current frame, saturating at sixteen
    always_ff @(negedge sclk or posedge chipSelB) begin
        if (chipSelB)
            fallCnt <= 5'h00;
        else if (fallCnt < 5'h10)
            fallCnt <= fallCnt + 5'h01;
    end
    always_ff @(posedge chipSelB) lastCnt <= fallCnt;
    always_ff @(negedge chipSelB) begin
        codeHeld   <= conversionCode;
        downAtFall <= !analogPowerOn;
    end

    ////////////////////////////////////////////////////////////////////////
    release_cs_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        chipSelB |-> serialResultOutOeB && !serialResultOut)
        else $error("data line driven while deselected");
    oe_window_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !chipSelB |-> serialResultOutOeB == (fallCnt == 5'h10))
        else $error("data line enable outside frame window");
    frame_bits_a: assert property (@(negedge sclk) disable iff (chipSelB)
        fallCnt < 5'h10 |-> serialResultOut ==
            (fallCnt < 5'h04 ? 1'b0 : codeHeld[5'h0f - fallCnt]))
        else $error("wrong serial bit");
    down_entry_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(chipSelB) && lastCnt >= 5'h02 && lastCnt <= 5'h09
            |-> ##[1:6] !analogPowerOn)
        else $error("no power-down after short frame");
    stay_on_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(chipSelB) && lastCnt >= 5'h0a |-> ##1 analogPowerOn [*6])
        else $error("power lost after long frame");
    wake_up_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !analogPowerOn && $fell(chipSelB) |-> ##[1:5] analogPowerOn)
        else $error("no power-up on select fall");
    hold_window_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !chipSelB && !downAtFall && fallCnt >= 5'h02 && fallCnt <= 5'h0c
            |-> sampleHold)
        else $error("sampler not holding during conversion");
    track_13_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !chipSelB && !downAtFall && fallCnt == 5'h10 |-> !sampleHold)
        else $error("sampler not tracking at frame end");
    wake_track_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !chipSelB && downAtFall && fallCnt >= 5'h03 |-> !sampleHold)
        else $error("sampler not tracking in wake frame");
    trusted_after_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(chipSelB) && lastCnt == 5'h10 |-> ##[1:8] resultTrusted)
        else $error("result not trusted after full frame");
endmodule : adcsr_readout_properties

bind adcsr_readout adcsr_readout_properties u_props (
    .core_clk, .rst_b, .sclk, .chipSelB, .conversionCode, .serialResultOut,
    .serialResultOutOeB, .analogPowerOn, .sampleHold, .resultTrusted);

`default_nettype wire

// ---- dv/adcsr_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module adcsr_host_model (
    input  wire logic core_clk,
    input  wire logic serialResultOut,
    input  wire logic serialResultOutOeB,
    output var  logic sclk,
    output var  logic chipSelB
);
    // released line shows the inverse of serialResultOut, which is low once the frame is done
    wire logic sdWire = serialResultOutOeB ? ~serialResultOut : serialResultOut;

    initial begin
        sclk     = 1'b1;
        chipSelB = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // n falls, clock idle high outside frames
    task automatic frame(input int n, output logic [15:0] word);
        word = 16'h0000;
        @(posedge core_clk);
        #3.1 chipSelB = 1'b0;
        for (int i = 1; i <= n; i++) begin
            #32;
            if (i <= 16)
                word[16-i] = sdWire;
            sclk = 1'b0;
            #32 sclk = 1'b1;
        end
        #16 chipSelB = 1'b1;
    endtask : frame
endmodule : adcsr_host_model

`default_nettype wire

// ---- dv/tb_adcsr_readout.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "adcsr_consts.svh"

module tb_adcsr_readout;
    logic        core_clk;
    logic        rst_b;
    logic        powerOnDownStrap;
    logic [11:0] conversionCode;
    wire  logic  sclk, chipSelB, serialResultOut, serialResultOutOeB;
    wire  logic  analogPowerOn, sampleHold, resultTrusted;
    int          n_errors;
    int          total_checks;
    logic        expOn, expTrusted;
    logic [15:0] word;
    int          corner [9] = '{1, 8, 16, 1, 9, 10, 2, 15, 16};

    adcsr_readout dut (.core_clk, .rst_b, .sclk, .chipSelB, .powerOnDownStrap,
        .conversionCode, .serialResultOut, .serialResultOutOeB,
        .analogPowerOn, .sampleHold, .resultTrusted);
    adcsr_host_model host (.core_clk, .serialResultOut, .serialResultOutOeB,
        .sclk, .chipSelB);

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // frame word: leading zeros then result, msb first
    function automatic logic [15:0] exp_word(input logic [11:0] code);
        return {`ADCSR_LEAD_VAL, code};
    endfunction : exp_word

    // power and trust after a frame of n falls
    function automatic logic exp_power(input int n, input logic prev);
        if (n < 2)
            return prev;
        return n >= 10;
    endfunction : exp_power

    task automatic close_out();
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic do_reset(input logic strap);
        rst_b            <= 1'b0;
        powerOnDownStrap <= strap;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (50) @(posedge core_clk);
        expOn      = !strap;
        expTrusted = !strap;
        check({14'h0, analogPowerOn, resultTrusted}, {14'h0, expOn, expTrusted});
        check({15'h0, sampleHold}, 16'h0000);
    endtask : do_reset

    // fixed gap after release keeps frames evenly spaced
    task automatic run(input int n);
        @(posedge core_clk);
        conversionCode <= 12'($urandom);
        repeat (4) @(posedge core_clk);
        host.frame(n, word);
        if (n >= 16)
            check(word, exp_word(conversionCode));
        expOn      = exp_power(n, expOn);
        expTrusted = exp_power(n, expTrusted);
        repeat (24) @(posedge core_clk);
        check({14'h0, analogPowerOn, resultTrusted}, {14'h0, expOn, expTrusted});
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_errors         = 0;
        total_checks     = 0;
        rst_b            = 1'b0;
        powerOnDownStrap = 1'b1;
        conversionCode   = 12'h000;
        void'($urandom(51));
        do_reset(1'b1);
        foreach (corner[i])
            run(corner[i]);
        repeat (16)
            run(1 + $urandom_range(15));
        do_reset(1'b0);
        repeat (16)
            run(1 + $urandom_range(15));
        close_out();
    end

    initial begin
        #200us;
        n_errors++;
        close_out();
    end
endmodule : tb_adcsr_readout

`default_nettype wire
